//--- hw/sensor_meas_ctrl.sv
// Measurement sequencing, averaging, result formatting and register file of the sensor.
`timescale 1ns/100ps
// Operation
// (RULE1) Results left-aligned, low bits zeroed by resolution.
// (RULE2) Result bytes: MSB index 2, LSB index 0.
// (RULE3) Host subtracts two^23 for signed value.
// (RULE4) Standby code bits 7:5 picks interval.
// (RULE5) IO bit 2 selects data pin drive.
// (RULE6) IO bit 0 selects three-wire wiring.
// (RULE7) Host writes zero to reserved IO bits.
// (RULE8) Averaging fields: skip, or 1 to 64.
// (RULE9) Mode field: sleep, forced, or normal.
// (RULE10) Status bit 3 high while measuring.
// (RULE11) Status bit 0 high during calibration read.
// (RULE12) Status reserved bits zero, read-only, resets zero.
// (RULE13) Forced runs once; normal repeats after standby.
// (RULE14) Results change only at measurement completion.
module sensor_meas_ctrl
  import sensor_meas_pkg::*;
#(
  parameter int CYCLES_MS = CYCLES_PER_MS
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_wdata,
  output      logic [7:0]  reg_rdata,
  input  wire logic        nvm_access,
  output      logic        adc_request,
  input  wire logic        adc_valid,
  input  wire logic [23:0] adc_data,
  output      logic        adc_select_press,
  output      logic        data_pin_drive_select,
  output      logic        three_wire_select
);

  // Refuse counts that the 32-bit standby counter cannot hold for the longest interval.
  if (CYCLES_MS < 1 || CYCLES_MS > (32'h7fffffff / STANDBY_MS[7]))
  begin : g_cycles_check
    $error("CYCLES_MS out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TEMP,
    ST_PRESS,
    ST_STORE,
    ST_STANDBY
  } phase_type;

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  // Number of samples minus one for a non-skip averaging code.
  function automatic logic [6:0] sample_last(input logic [2:0] code);
    sample_last = 7'((7'h01 << (code - 3'h1)) - 7'h01);
  endfunction : sample_last

  // Mask that clears the unused low bits for the resolution of a code.
  // (RULE1) resolution low-bit mask
  function automatic logic [23:0] res_mask(input logic [2:0] code);
    if (code == AVG_RES22)
      res_mask = MASK_RES22;
    else if (code == AVG_RES23)
      res_mask = MASK_RES23;
    else
      res_mask = MASK_RES24;
  endfunction : res_mask

  meas_ctrl_type ctrl;
  io_cfg_type    io_cfg;
  phase_type     phase;
  logic [6:0]    sample_count;
  logic [29:0]   accum;
  logic          waiting;
  logic [31:0]   standby_count;
  logic [23:0]   temp_raw;
  logic [23:0]   press_raw;
  logic [23:0]   temperature_result;
  logic [23:0]   pressure_result;
  logic          measuring;
  logic          nvm_reading;
  logic [2:0]    active_avg;
  logic [29:0]   sum_now;
  logic [23:0]   mean_now;
  logic          last_sample;
  logic [31:0]   standby_cycles;

  // ---------------------------------------------------------------------------
  // Combinational helpers
  // ---------------------------------------------------------------------------
  // Average is the sum shifted down by the log2 of the sample count.
  always_comb
  begin
    active_avg     = (phase == ST_PRESS) ? ctrl.press_avg : ctrl.temp_avg;
    sum_now        = accum + {6'h00, adc_data};
    mean_now       = 24'(sum_now >> (active_avg - 3'h1));
    last_sample    = (sample_count == sample_last(active_avg));
    // (RULE4) standby interval decode
    standby_cycles = 32'(STANDBY_MS[io_cfg.standby] * CYCLES_MS);
  end

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // Only the two configuration registers accept writes; status and results ignore them.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl   <= RESET_MEAS_CONTROL;
      io_cfg <= RESET_IO_CONFIG;
    end
    else
    begin
      if (reg_write && reg_addr == ADDR_MEAS_CONTROL)
        ctrl <= reg_wdata;
      // (RULE13) forced returns to sleep
      else if (phase == ST_STORE && ctrl.mode != MODE_NORMAL)
        ctrl.mode <= MODE_SLEEP;
      // (RULE7) reserved bits stored as written
      if (reg_write && reg_addr == ADDR_IO_CONFIG)
        io_cfg <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Measurement sequencer
  // ---------------------------------------------------------------------------
  // A mode change mid-cycle takes effect at the next cycle boundary, so a cycle
  // in progress always completes and its results stay coherent.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase         <= ST_IDLE;
      sample_count  <= 7'h00;
      accum         <= 30'h0;
      waiting       <= 1'b0;
      adc_request   <= 1'b0;
      standby_count <= 32'h0;
      temp_raw      <= 24'h0;
      press_raw     <= 24'h0;
    end
    else
    begin
      adc_request <= 1'b0;
      case (phase)
        ST_IDLE:
        begin
          // (RULE9) sleep holds, forced or normal starts
          if (ctrl.mode != MODE_SLEEP && !nvm_access)
          begin
            phase        <= ST_TEMP;
            sample_count <= 7'h00;
            accum        <= 30'h0;
            waiting      <= 1'b0;
          end
        end
        ST_TEMP,
        ST_PRESS:
        begin
          // (RULE8) skip code bypasses the measurement
          if (active_avg == AVG_SKIP)
          begin
            phase <= (phase == ST_TEMP) ? ST_PRESS : ST_STORE;
          end
          else if (!waiting)
          begin
            adc_request <= 1'b1;
            waiting     <= 1'b1;
          end
          else if (adc_valid)
          begin
            waiting <= 1'b0;
            // (RULE8) average over the selected count
            if (last_sample)
            begin
              if (phase == ST_TEMP)
                temp_raw <= mean_now & res_mask(active_avg);
              else
                press_raw <= mean_now & res_mask(active_avg);
              phase        <= (phase == ST_TEMP) ? ST_PRESS : ST_STORE;
              sample_count <= 7'h00;
              accum        <= 30'h0;
            end
            else
            begin
              sample_count <= sample_count + 7'h01;
              accum        <= sum_now;
            end
          end
        end
        ST_STORE:
        begin
          // (RULE13) normal waits standby, forced sleeps
          standby_count <= standby_cycles;
          phase         <= (ctrl.mode == MODE_NORMAL) ? ST_STANDBY : ST_IDLE;
        end
        ST_STANDBY:
        begin
          if (ctrl.mode != MODE_NORMAL)
            phase <= ST_IDLE;
          else if (standby_count <= 32'h1)
            phase <= ST_IDLE;
          else
            standby_count <= standby_count - 32'h1;
        end
        default:
          phase <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------------------
  // Both results move together in the store step; reads in between see one cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temperature_result <= 24'h0;
      pressure_result    <= 24'h0;
    end
    // (RULE14) update only on completion
    else if (phase == ST_STORE)
    begin
      // (RULE1) skipped quantities keep the last value
      if (ctrl.temp_avg != AVG_SKIP)
        temperature_result <= temp_raw;
      if (ctrl.press_avg != AVG_SKIP)
        pressure_result <= press_raw;
    end
  end

  // ---------------------------------------------------------------------------
  // Status and outputs
  // ---------------------------------------------------------------------------
  // Status bits follow the sequencer and the calibration loader one cycle late.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      measuring             <= 1'b0;
      nvm_reading           <= 1'b0;
      adc_select_press      <= 1'b0;
      data_pin_drive_select <= 1'b0;
      three_wire_select     <= 1'b0;
    end
    else
    begin
      // (RULE10) busy from start to store
      measuring             <= (phase == ST_TEMP || phase == ST_PRESS);
      // (RULE11) calibration read in progress
      nvm_reading           <= nvm_access;
      adc_select_press      <= (phase == ST_PRESS);
      // (RULE5) data pin drive type
      data_pin_drive_select <= io_cfg.data_pin_drive_select;
      // (RULE6) three-wire wiring select
      three_wire_select     <= io_cfg.three_wire_select;
    end
  end

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------
  // Read data is registered; unmapped addresses return zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= READ_UNMAPPED;
    // (RULE12) reserved status bits read zero
    else if (reg_addr == ADDR_DEVICE_STATUS)
      reg_rdata <= {4'h0, measuring, 2'h0, nvm_reading};
    else if (reg_addr == ADDR_MEAS_CONTROL)
      reg_rdata <= ctrl;
    else if (reg_addr == ADDR_IO_CONFIG)
      reg_rdata <= io_cfg;
    // (RULE2) byte index 2 at lowest address
    else if (reg_addr == ADDR_PRESS_BASE)
      reg_rdata <= pressure_result[23:16];
    else if (reg_addr == ADDR_PRESS_BASE + 8'h01)
      reg_rdata <= pressure_result[15:8];
    else if (reg_addr == ADDR_PRESS_BASE + 8'h02)
      reg_rdata <= pressure_result[7:0];
    else if (reg_addr == ADDR_TEMP_BASE)
      reg_rdata <= temperature_result[23:16];
    else if (reg_addr == ADDR_TEMP_BASE + 8'h01)
      reg_rdata <= temperature_result[15:8];
    else if (reg_addr == ADDR_TEMP_BASE + 8'h02)
      reg_rdata <= temperature_result[7:0];
    else
      reg_rdata <= READ_UNMAPPED;
  end

endmodule : sensor_meas_ctrl

//--- hw/sensor_meas_pkg.sv
// Register map, field layouts and timing constants of the measurement control block.
package sensor_meas_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets, reset values and unmapped read value
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_DEVICE_STATUS = 8'hf3;
  localparam logic [7:0] ADDR_MEAS_CONTROL  = 8'hf4;
  localparam logic [7:0] ADDR_IO_CONFIG     = 8'hf5;
  localparam logic [7:0] ADDR_PRESS_BASE    = 8'hf7;  // Index 0, 1, 2 at base+2, +1, +0.
  localparam logic [7:0] ADDR_TEMP_BASE     = 8'hfa;
  localparam logic [7:0] RESET_MEAS_CONTROL = 8'h00;
  localparam logic [7:0] RESET_IO_CONFIG    = 8'h00;
  localparam logic [7:0] RESET_STATUS       = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // ---------------------------------------------------------------------------
  // Field layouts and codes
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] temp_avg;
    logic [2:0] press_avg;
    logic [1:0] mode;
  } meas_ctrl_type;

  typedef struct packed {
    logic [2:0] standby;
    logic [1:0] rsv_hi;
    logic       data_pin_drive_select;
    logic       rsv_lo;
    logic       three_wire_select;
  } io_cfg_type;

  typedef struct packed {
    logic [3:0] rsv_hi;
    logic       measuring;
    logic [1:0] rsv_lo;
    logic       nvm_reading;
  } status_type;

  localparam logic [2:0] AVG_SKIP      = 3'h0;
  localparam logic [2:0] AVG_RES22     = 3'h1;
  localparam logic [2:0] AVG_RES23     = 3'h2;
  localparam logic [1:0] MODE_SLEEP    = 2'h0;
  localparam logic [1:0] MODE_NORMAL   = 2'h3;
  localparam logic [23:0] MASK_RES22   = 24'hfffffc;
  localparam logic [23:0] MASK_RES23   = 24'hfffffe;
  localparam logic [23:0] MASK_RES24   = 24'hffffff;

  // ---------------------------------------------------------------------------
  // Standby times in milliseconds, indexed by the 3-bit standby code
  // ---------------------------------------------------------------------------
  localparam int STANDBY_MS [8] = '{1, 5, 50, 250, 500, 1000, 2000, 4000};
  localparam int CLOCK_MHZ      = 100;
  localparam int CYCLES_PER_MS  = CLOCK_MHZ * 1000;

endpackage : sensor_meas_pkg

//--- tb/sensor_meas_ctrl_assertions.sv
// Port-level checks of the measurement control block.
`timescale 1ns/100ps
module meas_checker
  import sensor_meas_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       nvm_access,
  input wire logic       adc_request,
  input wire logic       adc_select_press,
  input wire logic       data_pin_drive_select,
  input wire logic       three_wire_select
);
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  drive_copy_a: assert property (
    reg_write && reg_addr == 8'hf5 ##1 !reg_write |=> data_pin_drive_select == $past(reg_wdata[2], 2))
    else $error("drive select pin wrong");
  wire_copy_a: assert property (
    reg_write && reg_addr == 8'hf5 ##1 !reg_write |=> three_wire_select == $past(reg_wdata[0], 2))
    else $error("wiring select pin wrong");
  io_hold_a: assert property (
    !(reg_write && reg_addr == 8'hf5) [*2] |=> $stable(three_wire_select))
    else $error("wiring select moved without a write");
  status_rsv_a: assert property (
    $past(reg_addr) == 8'hf3 |-> (reg_rdata & 8'hf6) == 8'h00)
    else $error("reserved status bits set");
  nvm_flag_a: assert property (
    $stable(nvm_access) [*4] ##1 reg_addr == 8'hf3 |=> reg_rdata[0] == $past(nvm_access, 2))
    else $error("calibration flag wrong");
  req_pulse_a: assert property (
    adc_request |=> !adc_request)
    else $error("sample request longer than one cycle");
  cfg_back_a: assert property (
    reg_write && (reg_addr == 8'hf4 || reg_addr == 8'hf5) ##1 !reg_write && $stable(reg_addr)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("configuration read back wrong");
  busy_flag_a: assert property (
    adc_request && reg_addr == 8'hf3 ##1 reg_addr == 8'hf3 [*2] |=> reg_rdata[3])
    else $error("busy flag low during a measurement");
  // Main scenarios: pressure sampling, normal mode entry, calibration flag read.
  cover property (adc_request && adc_select_press);
  cover property (reg_write && reg_addr == 8'hf4 && reg_wdata[1:0] == 2'h3);
  cover property (nvm_access && reg_addr == 8'hf3);
endmodule : meas_checker

bind sensor_meas_ctrl meas_checker chk (.clk, .rst_n, .reg_addr, .reg_write, .reg_wdata,
  .reg_rdata, .nvm_access, .adc_request, .adc_select_press, .data_pin_drive_select,
  .three_wire_select);

//--- tb/adc_model.sv
// Behavioural converter answering each sample request after a set latency.
`timescale 1ns/100ps
module adc_model
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        adc_request,
  input  wire logic        adc_select_press,
  input  wire logic [3:0]  latency,
  input  wire logic [23:0] temp_value,
  input  wire logic [23:0] press_value,
  output      logic        adc_valid,
  output      logic [23:0] adc_data
);
  logic [3:0] count;
  // Counts down the open request; data toggles outside the valid cycle so stale data never passes.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count     <= 4'h0;
      adc_valid <= 1'b0;
      adc_data  <= 24'h0;
    end
    else
    begin
      adc_valid <= count == 4'h1;
      adc_data  <= count == 4'h1 ? (adc_select_press ? press_value : temp_value) : ~adc_data;
      if (adc_request)
        count <= latency;
      else if (count != 4'h0)
        count <= count - 4'h1;
    end
  end
endmodule : adc_model

//--- tb/test_pressure_sensor_measure_control.sv
// Self-checking bench of the measurement control block.
`timescale 1ns/100ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, g, x); end end
module test_pressure_sensor_measure_control
  import sensor_meas_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_write = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        nvm_access = 1'b0;
  logic [3:0]  latency = 4'h1;
  logic [23:0] temp_value = 24'h0;
  logic [23:0] press_value = 24'h0;
  logic [23:0] adc_data, exp_t = 24'h0, exp_p = 24'h0;
  logic [7:0]  reg_rdata, q, v, m;
  logic        adc_request, adc_valid, adc_select_press, data_pin_drive_select, three_wire_select;
  logic [31:0] seed = 32'h2a9b8003;
  logic [7:0]  exp_q[$];
  int          bad_count = 0;
  int          compares = 0;
  int          reqs = 0;
  int          i;

  sensor_meas_ctrl #(.CYCLES_MS(10)) dut (.clk, .rst_n, .reg_addr, .reg_write, .reg_wdata,
    .reg_rdata, .nvm_access, .adc_request, .adc_valid, .adc_data, .adc_select_press,
    .data_pin_drive_select, .three_wire_select);
  adc_model partner (.clk, .rst_n, .adc_request, .adc_select_press, .latency, .temp_value,
    .press_value, .adc_valid, .adc_data);

  // ---------------------------------------------------------------------------
  // Clock, request count and answer checking
  // ---------------------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk)
    if (adc_request === 1'b1)
      reqs++;
  // Answers are compared mid-cycle, where the registered read data has settled.
  always @(negedge clk)
    if (exp_q.size() > 0)
    begin
      m = exp_q.pop_front();
      `CHK(reg_rdata, m)
    end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [23:0] mask(input logic [2:0] c);
    return c == 3'h1 ? 24'hfffffc : c == 3'h2 ? 24'hfffffe : 24'hffffff;
  endfunction : mask

  // One access: inputs move just after an edge, the answer is taken after the next edge.
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_write = w;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_write = 1'b0;
    q = reg_rdata;
  endtask : acc

  task automatic chk(input logic [7:0] a, input logic [7:0] x);
    acc(a, 1'b0, 8'h00);
    exp_q.push_back(x);
  endtask : chk

  task automatic final_report();
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // A forced run; old results must stand until the new ones are stored.
  task automatic measure(input logic [2:0] t, input logic [2:0] p, input logic [1:0] md);
    int n;
    logic [23:0] raw;
    logic        busy;
    temp_value  = 24'(rnd());
    press_value = 24'(rnd());
    latency     = 4'(rnd() % 7 + 1);
    acc(8'hf4, 1'b1, {t, p, md});
    chk(8'hfc, exp_t[7:0]);
    if (t != 3'h0)
      exp_t = temp_value & mask(t);
    if (p != 3'h0)
      exp_p = press_value & mask(p);
    // Poll status while the run is under way; every code used lasts beyond this window.
    busy = 1'b0;
    repeat (8)
    begin
      acc(8'hf3, 1'b0, 8'h00);
      busy = busy | q[3];
    end
    `CHK(busy, 1'b1)
    q = 8'h01;
    for (n = 0; n < 2000 && q[1:0] != 2'h0; n++)
      acc(8'hf4, 1'b0, 8'h00);
    if (q[1:0] != 2'h0)
    begin
      bad_count++;
      final_report();
    end
    acc(8'hf3, 1'b0, 8'h00);
    chk(8'hf3, 8'h00);
    for (n = 0; n < 3; n++)
    begin
      chk(8'(8'hf7 + n), exp_p[23 - 8 * n -: 8]);
      chk(8'(8'hfa + n), exp_t[23 - 8 * n -: 8]);
      raw = {raw[15:0], q};
    end
    // Host view: the three bytes form an offset value centred on two to the 23rd.
    `CHK(32'(raw) - 32'h00800000, 32'(exp_t) - 32'h00800000)
  endtask : measure

  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(8'hf3, 8'h00);
    chk(8'hf5, 8'h00);
    acc(8'hf3, 1'b1, 8'hff);
    chk(8'hf3, 8'h00);
    chk(8'h10, 8'h00);
    // Reserved bits are kept at zero by the host.
    // reserved bits zero
    repeat (4)
    begin
      v = 8'(rnd()) & 8'he5;
      acc(8'hf5, 1'b1, v);
      chk(8'hf5, v);
      `CHK({data_pin_drive_select, three_wire_select}, {v[2], v[0]})
    end
    for (i = 1; i < 8; i++)
      measure(3'(i), 3'(8 - i), 2'(1 + i % 2));
    measure(3'h0, 3'h3, 2'h1);
    acc(8'hf5, 1'b1, 8'h00);
    reqs = 0;
    acc(8'hf4, 1'b1, 8'h27);
    repeat (300) @(posedge clk);
    #1;
    `CHK(reqs >= 6, 1'b1)
    acc(8'hf4, 1'b1, 8'h00);
    repeat (100) @(posedge clk);
    #1;
    reqs = 0;
    nvm_access = 1'b1;
    repeat (2) acc(8'hf3, 1'b0, 8'h00);
    chk(8'hf3, 8'h01);
    nvm_access = 1'b0;
    repeat (2) acc(8'hf3, 1'b0, 8'h00);
    chk(8'hf3, 8'h00);
    `CHK(reqs == 0, 1'b1)
    final_report();
  end
endmodule : test_pressure_sensor_measure_control
